// *** afe_pkg.sv ***
/*
 Package for the serial port and ready strobe block: timing constants,
 field layouts, reset values and carrier structs.
 Assumes a single 25 MHz system clock stands in for the master clock.
*/
// Functional notes
// - Idle ready pin drives high if float select is 1, floats if 0.
// - One active-low ready pulse per finished conversion, fixed width.
// - Pulse lasts half a sample-rate period; repeats at output rate.
// - Ready pulse runs free of serial activity, never latched.
// - External clock select bypasses crystal; oscillator enable reflects it.
// - Chip select low frames a transaction; nothing moves while high.
// - Serial port ignores traffic while hard reset is low.
// - Inputs sampled on rising serial clock, outputs launched on falling.
// - Modes 0,0 and 1,1 accepted; host switches only with select high.
// - Serial clock is asynchronous to the master clock; synchronised.
// - Serial output floats except while servicing a read.
// - Half-duplex: never shifting in and driving out together.
// - Input after read command or with select high has no effect.
// - Hard reset low returns every register to default, stops clocks; here crystal_osc_enable and rate_cfg are left as they are.
// - Modulator clock is master clock over 1, 2, 4 or 8.
// - Sample-rate clock is modulator clock over four.
// - Output rate is sample rate over ratio 32..4096, default 256.
package afe_pkg;
   localparam int         CLK_HZ         = 25_000_000;
   localparam int         CMD_BITS       = 8;
   localparam int         CMD_RW_BIT     = 0;
   localparam logic [1:0] PRE_RESET      = 2'h0;
   localparam logic [2:0] OSR_RESET      = 3'h3;
   localparam int         OSR_MIN_LOG2   = 5;
   localparam int         DIV4_LOG2      = 2;
   localparam int         CNT_W          = 18;
   localparam logic       FLOAT_RESET    = 1'h0;
   localparam logic       EXTCLK_RESET   = 1'h0;

   typedef struct packed {
      logic [1:0] prescale;
      logic [2:0] decimation_ratio;
   } afe_rate_s;

   typedef struct packed {
      logic cs_n;
      logic sck;
      logic sdi;
   } afe_spi_in_s;

   typedef struct packed {
      logic sdo;
      logic sdo_oe;
   } afe_spi_out_s;

   typedef struct packed {
      logic       valid;
      logic       is_read;
      logic [7:0] cmd;
      logic [7:0] wdata;
   } afe_cmd_s;
endpackage

// *** afe_sync2.sv ***
/*
 Two-flop synchroniser for inputs from outside the clock domain.
 Assumes the stage-one flop feeds only stage two.
*/
`timescale 1ns/1ps
module afe_sync2 #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         sys_rst,
   // Data
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] stage1;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stage1 <= '0;
         dout   <= '0;
      end else begin
         stage1 <= din;
         dout   <= stage1;
      end
   end
endmodule // afe_sync2

// *** afe_serial_ready.sv ***
/*
 Device side serial slave port and conversion ready strobe generator.
 Assumes serial pins and hard reset are asynchronous and oversampled by clk
 (serial clock must be well below clk/4 in this implementation).
*/
`timescale 1ns/1ps
module afe_serial_ready
   import afe_pkg::*;
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              hard_reset_n,
   // Serial pins
   input  wire afe_pkg::afe_spi_in_s spi_in,
   output afe_pkg::afe_spi_out_s  spi_out,
   input  wire logic [7:0]        read_data,
   output afe_pkg::afe_cmd_s      cmd_out,
   // Configuration
   input  wire afe_pkg::afe_rate_s rate_cfg,
   input  wire logic              ready_pin_float_select,
   input  wire logic              external_clock_select,
   // Ready pin and clock pins
   output logic                   conversion_ready_strobe_n,
   output logic                   ready_oe,
   output logic                   crystal_osc_enable,
   output logic                   sample_rate_tick
);
   import afe_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   // Flops clear to zero, so the synchronised hard reset holds the port idle first
   logic [3:0] raw_pins;
   logic [3:0] sync_pins;
   logic       cs_n_s, sck_s, sdi_s, rst_n_s;

   assign raw_pins = {hard_reset_n, spi_in.cs_n, spi_in.sck, spi_in.sdi};

   afe_sync2 #(.W(4)) u_sync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .din     (raw_pins),
      .dout    (sync_pins)
   );
   assign {rst_n_s, cs_n_s, sck_s, sdi_s} = sync_pins;

   logic sck_d;
   logic port_rst;
   logic sck_rise, sck_fall;

   assign port_rst = sys_rst | ~rst_n_s | cs_n_s;

   always_ff @(posedge clk) begin
      if (sys_rst) sck_d <= 1'h0;
      else         sck_d <= sck_s;
   end
   // Mode 1,1 idles high: first falling edge before data is harmless
   assign sck_rise = sck_s & ~sck_d;
   assign sck_fall = ~sck_s & sck_d;

   ////////////////////////////////////////////////////////////////////////
   // Serial state machine
   typedef enum logic [2:0] {
      ST_CMD   = 3'b001,
      ST_WRITE = 3'b010,
      ST_READ  = 3'b100
   } afe_state_e;

   afe_state_e state;
   logic [2:0] bit_cnt;
   logic [7:0] shreg;
   logic [7:0] cmd_hold;
   logic [7:0] txreg;

   always_ff @(posedge clk) begin
      if (port_rst) begin
         state    <= ST_CMD;
         bit_cnt  <= 3'h0;
         shreg    <= 8'h00;
         cmd_hold <= 8'h00;
         cmd_out  <= '0;
      end else begin
         cmd_out.valid <= 1'h0;
         case (state)
            ST_CMD: if (sck_rise) begin
               shreg   <= {shreg[6:0], sdi_s};
               bit_cnt <= bit_cnt + 3'h1;
               if (bit_cnt == 3'h7) begin
                  cmd_hold      <= {shreg[6:0], sdi_s};
                  cmd_out.valid <= 1'h1;
                  cmd_out.cmd   <= {shreg[6:0], sdi_s};
                  cmd_out.wdata <= 8'h00;
                  cmd_out.is_read <= sdi_s;
                  state <= sdi_s ? ST_READ : ST_WRITE;
               end
            end
            ST_WRITE: if (sck_rise) begin
               shreg   <= {shreg[6:0], sdi_s};
               bit_cnt <= bit_cnt + 3'h1;
               if (bit_cnt == 3'h7) begin
                  cmd_out.valid   <= 1'h1;
                  cmd_out.is_read <= 1'h0;
                  cmd_out.cmd     <= cmd_hold;
                  cmd_out.wdata   <= {shreg[6:0], sdi_s};
               end
            end
            ST_READ: ; // Input ignored after a read command
            default: state <= ST_CMD;
         endcase
      end
   end

   // Output shifter, launched on falling edges only in read state
   // Loads on entry only; a second byte in the same read shifts out zeros
   always_ff @(posedge clk) begin
      if (port_rst) begin
         txreg   <= 8'h00;
         spi_out <= '0;
      end else if (state == ST_READ) begin
         spi_out.sdo_oe <= 1'h1;
         if (sck_fall) begin
            spi_out.sdo <= txreg[7];
            txreg       <= (txreg[6:0] == 7'h00 && spi_out.sdo_oe == 1'h0) ?
                           read_data : {txreg[6:0], 1'h0};
         end else if (!spi_out.sdo_oe) begin
            txreg <= read_data;
         end
      end else begin
         spi_out <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Clock source and rate dividers
   always_ff @(posedge clk) begin
      if (sys_rst) crystal_osc_enable <= ~EXTCLK_RESET;
      else         crystal_osc_enable <= ~external_clock_select;
   end

   afe_rate_s  rate_q;
   logic [CNT_W-1:0] pre_cnt;
   logic [CNT_W-1:0] dec_cnt;
   logic [CNT_W-1:0] dm_period;
   logic [CNT_W-1:0] dr_period;
   logic             core_rst;

   assign core_rst  = sys_rst | ~rst_n_s;
   assign dm_period = CNT_W'(1) << (rate_cfg.prescale + DIV4_LOG2);
   assign dr_period = CNT_W'(1) << (rate_cfg.decimation_ratio + OSR_MIN_LOG2);

   always_ff @(posedge clk) begin
      if (core_rst || rate_q != rate_cfg) begin
         rate_q           <= rate_cfg;
         pre_cnt          <= '0;
         dec_cnt          <= '0;
         sample_rate_tick <= 1'h0;
      end else begin
         sample_rate_tick <= 1'h0;
         if (pre_cnt == dm_period - CNT_W'(1)) begin
            pre_cnt          <= '0;
            sample_rate_tick <= 1'h1;
            dec_cnt <= (dec_cnt == dr_period - CNT_W'(1)) ? '0 : dec_cnt + CNT_W'(1);
         end else begin
            pre_cnt <= pre_cnt + CNT_W'(1);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Ready strobe: low for the first half sample period of each frame
   always_ff @(posedge clk) begin
      if (core_rst) begin
         conversion_ready_strobe_n <= 1'h1;
         ready_oe                  <= FLOAT_RESET;
      end else begin
         // Free running, no tie to serial reads
         conversion_ready_strobe_n <= ~(dec_cnt == '0 && rate_q == rate_cfg &&
                                        pre_cnt < (dm_period >> 1));
         // Same rate gate as the strobe, so a rate change never drives a runt high
         ready_oe <= ready_pin_float_select |
                     (dec_cnt == '0 && rate_q == rate_cfg &&
                      pre_cnt < (dm_period >> 1));
      end
   end

   chk_ready_width: assert property (@(posedge clk) disable iff (core_rst)
      $fell(conversion_ready_strobe_n) && rate_q == rate_cfg |->
      ready_oe throughout (!conversion_ready_strobe_n [*2]))
      else $error("ready pulse too short");
   chk_sdo_float: assert property (@(posedge clk) disable iff (sys_rst)
      state != ST_READ |=> !spi_out.sdo_oe)
      else $error("sdo driven outside read");
   chk_cs_abort: assert property (@(posedge clk) disable iff (sys_rst)
      cs_n_s |=> state == ST_CMD && bit_cnt == 3'h0)
      else $error("select high did not abort");
   chk_reset_block: assert property (@(posedge clk) disable iff (sys_rst)
      !rst_n_s |=> !cmd_out.valid && !spi_out.sdo_oe)
      else $error("traffic during hard reset");
   chk_idle_high: assert property (@(posedge clk) disable iff (core_rst)
      ready_pin_float_select && $stable(ready_pin_float_select) |=> ready_oe)
      else $error("ready not driven");
   chk_osc_sel: assert property (@(posedge clk) disable iff (sys_rst)
      external_clock_select |=> !crystal_osc_enable)
      else $error("oscillator not disabled");
   chk_read_quiet: assert property (@(posedge clk) disable iff (sys_rst)
      state == ST_READ && !port_rst |=> !cmd_out.valid)
      else $error("input acted after read");
   chk_half_duplex: assert property (@(posedge clk) disable iff (sys_rst)
      spi_out.sdo_oe |-> state == ST_READ || $past(state) == ST_READ)
      else $error("half duplex broken");
   // Pin-level checks of the ready strobe, the hard reset hold and the sample tick
   chk_pulse_driven: assert property (@(posedge clk) disable iff (core_rst)
      !conversion_ready_strobe_n |-> ready_oe)
      else $error("ready pulse not driven");
   chk_float_idle: assert property (@(posedge clk) disable iff (core_rst)
      !$past(ready_pin_float_select) && conversion_ready_strobe_n |-> !ready_oe)
      else $error("idle ready pin not floating");
   chk_core_hold: assert property (@(posedge clk) disable iff (sys_rst)
      !rst_n_s |=> conversion_ready_strobe_n && !sample_rate_tick)
      else $error("ready strobe ran during hard reset");
   chk_tick_single: assert property (@(posedge clk) disable iff (core_rst)
      sample_rate_tick |=> !sample_rate_tick)
      else $error("sample tick longer than one cycle");
endmodule // afe_serial_ready

// *** afe_host_model.sv ***
/*
 Host side serial master model: frames by chip select, modes 0,0 and 1,1.
 Assumes the bench clock; pins move on its falling edge only.
*/
`timescale 1ns/1ps
module afe_host_model (
   // Clock
   input  wire logic                  clk,
   // Serial pins
   output afe_pkg::afe_spi_in_s       spi_in,
   input  wire afe_pkg::afe_spi_out_s spi_out
);
   import afe_pkg::*;
   // Wide margin over the 4 clk floor so synchroniser lag never bites
   localparam int HALF = 8;
   logic busy = 1'b0;
   initial spi_in = 3'h4;
   // Junk on the data line outside frames
   always @(negedge clk) begin
      if (!busy) spi_in.sdi <= ~spi_in.sdi;
   end
   task automatic xfer(input logic cpol, input logic [15:0] word, input int nbits,
                       output logic [7:0] rd, output logic oe_early);
      rd = 8'h00;
      oe_early = 1'b0;
      @(negedge clk);
      busy = 1'b1;
      spi_in.sck <= cpol;
      repeat (HALF) @(negedge clk);
      spi_in.cs_n <= 1'b0;
      for (int i = 0; i < nbits; i++) begin
         repeat (HALF) @(negedge clk);
         spi_in.sck <= 1'b0;
         spi_in.sdi <= word[15-i];
         repeat (HALF) @(negedge clk);
         spi_in.sck <= 1'b1;
         if (i < 8) oe_early |= spi_out.sdo_oe;
         // A released line reads inverted, so an undriven bit never passes
         else rd = {rd[6:0], spi_out.sdo_oe ? spi_out.sdo : ~spi_out.sdo};
      end
      repeat (HALF) @(negedge clk);
      spi_in.sck <= cpol;
      repeat (HALF) @(negedge clk);
      spi_in.cs_n <= 1'b1;
      repeat (HALF) @(negedge clk);
      spi_in.sck <= 1'b0;
      busy = 1'b0;
   endtask
endmodule // afe_host_model

// *** afe_serial_port_and_ready_strobe_bench.sv ***
/*
 Bench for the serial port and ready strobe block.
 Assumes the host model drives the serial pins; no counts shortened.
*/
`timescale 1ns/1ps
module afe_serial_port_and_ready_strobe_bench;
   import afe_pkg::*;
   logic         clk = 1'b0;
   logic         sys_rst = 1'b1;
   logic         hard_reset_n = 1'b1;
   logic [7:0]   read_data = 8'hc3;
   afe_rate_s    rate_cfg = 5'h00;
   logic         flt = 1'b0;
   logic         ext = 1'b0;
   logic         strobe_n, ready_oe, osc_en, tick, oe_any, oe_early, rdy_any;
   logic [7:0]   rd;
   afe_spi_in_s  spi_in;
   afe_spi_out_s spi_out;
   afe_cmd_s     cmd_out;
   afe_cmd_s     seen[$];
   int           bad_count = 0;
   int           tests_run = 0;
   int           lo, per, tk;
   initial forever #20 clk = ~clk;
   afe_serial_ready dut (.clk(clk), .sys_rst(sys_rst), .hard_reset_n(hard_reset_n),
      .spi_in(spi_in), .spi_out(spi_out), .read_data(read_data), .cmd_out(cmd_out),
      .rate_cfg(rate_cfg), .ready_pin_float_select(flt), .external_clock_select(ext),
      .conversion_ready_strobe_n(strobe_n), .ready_oe(ready_oe),
      .crystal_osc_enable(osc_en), .sample_rate_tick(tick));
   afe_host_model host (.clk(clk), .spi_in(spi_in), .spi_out(spi_out));
   always @(posedge clk) begin
      if (cmd_out.valid === 1'b1) seen.push_back(cmd_out);
      if (spi_out.sdo_oe === 1'b1) oe_any <= 1'b1;
      if (strobe_n === 1'b0 || tick === 1'b1) rdy_any <= 1'b1;
   end
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      $display("Compared %0d, mismatched %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic wait_lvl(input logic v);
      int n = 0;
      while (strobe_n !== v) begin
         @(negedge clk);
         n++;
         if (n > 5000) begin
            bad_count++;
            stop_test();
         end
      end
   endtask
   // Low width, fall to fall period and sample ticks within one period
   task automatic measure;
      per = 0;
      tk = 0;
      wait_lvl(1'b1);
      wait_lvl(1'b0);
      while (strobe_n === 1'b0 && per < 3000) begin
         tk += (tick === 1'b1);
         @(negedge clk);
         per++;
      end
      lo = per;
      while (strobe_n === 1'b1 && per < 3000) begin
         tk += (tick === 1'b1);
         @(negedge clk);
         per++;
      end
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      oe_any = 1'b0;
      repeat (20) @(negedge clk);
      sys_rst = 1'b0;
      chk(ready_oe, 32'h0);
      chk(osc_en, 32'h1);
      ext = 1'b1;
      repeat (4) @(negedge clk);
      chk(osc_en, 32'h0);
      ext = 1'b0;
      $display("clock select test done");
      flt = 1'b1;
      // Period held at 1024 cycles so each pass stays short
      for (int p = 0; p < 4; p++) begin
         rate_cfg = {p[1:0], 3'(3 - p)};
         measure();
         measure();
         chk(lo, 2 << p);
         chk(per, 1024);
         chk(tk, 32 << (3 - p));
      end
      flt = 1'b0;
      // Floating idle pin must still be driven low for the pulse
      wait_lvl(1'b1);
      wait_lvl(1'b0);
      chk(ready_oe, 32'h1);
      repeat (20) @(negedge clk);
      chk(ready_oe, 32'h0);
      $display("ready strobe test done");
      host.xfer(1'b0, 16'ha45a, 16, rd, oe_early);
      chk(seen.size(), 2);
      chk({seen[0].is_read, seen[0].cmd}, 9'h0a4);
      chk(seen[1].wdata, 8'h5a);
      chk(oe_any, 32'h0);
      seen.delete();
      // Read in mode 1,1 with ones on the data line after the command
      host.xfer(1'b1, 16'h41ff, 16, rd, oe_early);
      chk(rd, 8'hc3);
      chk(oe_early, 32'h0);
      chk(seen.size(), 1);
      chk({seen[0].is_read, seen[0].cmd}, 9'h141);
      chk(spi_out.sdo_oe, 32'h0);
      $display("read and write test done");
      seen.delete();
      host.xfer(1'b0, 16'h1000, 4, rd, oe_early);
      host.xfer(1'b0, 16'h2299, 16, rd, oe_early);
      chk(seen.size(), 2);
      chk(seen[0].cmd, 8'h22);
      chk(seen[1].wdata, 8'h99);
      $display("abort test done");
      hard_reset_n = 1'b0;
      seen.delete();
      // Let the reset pass the synchroniser before watching the strobe
      repeat (4) @(negedge clk);
      oe_any = 1'b0;
      rdy_any = 1'b0;
      host.xfer(1'b1, 16'h4100, 16, rd, oe_early);
      chk(seen.size(), 0);
      chk(oe_any, 32'h0);
      chk(rdy_any, 32'h0);
      hard_reset_n = 1'b1;
      repeat (8) @(negedge clk);
      chk(strobe_n, 32'h0);
      host.xfer(1'b0, 16'h3c77, 16, rd, oe_early);
      chk(seen[0].cmd, 8'h3c);
      $display("hard reset test done");
      stop_test();
   end
endmodule // afe_serial_port_and_ready_strobe_bench
